// File: flash_block_write_protect.sv
// What this block does
// - refuse program or erase inside protected range
// - chip erase only when protect code zero
// - status locked when disable set, pin low, quad bit clear
// - status writable when disable clear or pin high
// - quad bit turns shared pins into data lines
// - 64KB: codes 1-10 protect power-of-two blocks
// - 64KB: codes 11-15 protect 768..1024 blocks
// - select 0 counts from top, 1 bottom
// - 256KB: codes 1-8 powers, 9-15 all
// - opcodes c0 and 17 need no enable
// - top/bottom select is one-way to bottom
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/10ps
module flash_block_write_protect (
  input wire logic clk_i, // 50 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic wb_we_i, // wishbone write
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_cyc_i, // wishbone cycle
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic wp_n_pin_i, // shared pin: write protect, low active
  input wire logic hold_n_pin_i, // shared pin: hold/reset, low active
  output logic quad_lines_en_o, // pins serve as data_line_two/three
  output logic write_protect_active_o, // wp function sees pin low
  output logic hold_active_o, // hold function sees pin low
  output logic array_op_o, // one-cycle program/erase request
  output logic [7:0] array_op_code_o, // opcode of that request
  output logic [25:0] array_op_addr_o // target address of request
);
  import flash_protect_pkg::*;

  logic [7:0] status;
  logic top_bottom_select;
  logic large_blocks;
  logic [ADDR_W-1:0] target;
  logic [15:0] result;
  logic [7:0] read_param;
  logic [7:0] bank_addr;
  logic [1:0] pins_sync;
  logic wp_level;
  logic sr_locked;
  logic write_enable_latch;
  logic [3:0] protect_code;
  logic [CNT_W-1:0] prot_count;
  logic target_protected;
  logic req;
  logic wr_en;
  logic cmd_stb;
  logic [7:0] cmd_op;
  logic [7:0] cmd_data;
  logic is_array_op;
  logic is_chip_erase;
  logic [4:0] flags;
  logic set_wel;
  logic clr_wel;
  logic do_status;
  logic do_array;
  logic do_param;
  logic do_bank;
  logic target_low;

  pin_sync #(.W(2)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({hold_n_pin_i, wp_n_pin_i}),
    .sync_o(pins_sync)
  );

  protect_range_decoder u_range (
    .code_i(protect_code),
    .tbs_i(top_bottom_select),
    .large_i(large_blocks),
    .addr_i(target),
    .count_o(prot_count),
    .protected_o(target_protected)
  );

  assign protect_code = status[ST_CODE_LSB +: 4];
  assign write_enable_latch = status[ST_WEL];

  // with quad on, the pins are data lines and the hardware lock is off
  assign quad_lines_en_o = status[ST_QE];
  assign write_protect_active_o = ~status[ST_QE] & ~pins_sync[0];
  assign hold_active_o = ~status[ST_QE] & ~pins_sync[1];
  assign wp_level = status[ST_QE] | pins_sync[0];
  assign sr_locked = status[ST_SWD] & ~wp_level;

  // bus handshake: ack one cycle after the request, dropped after one
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & wb_ack_o;
  assign cmd_stb = wr_en & (wb_adr_i == OFS_COMMAND) & wb_sel_i[0];
  assign cmd_op = wb_dat_i[7:0];
  assign cmd_data = wb_dat_i[15:8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req & ~wb_ack_o) begin
      unique case (wb_adr_i)
        OFS_STATUS: wb_dat_o <= {24'h0, status};
        OFS_FUNCTION: wb_dat_o <= {30'h0, top_bottom_select, 1'b0};
        OFS_CONFIG: wb_dat_o <= {31'h0, large_blocks};
        OFS_TARGET: wb_dat_o <= {6'h0, target};
        OFS_RESULT: wb_dat_o <= {16'h0, result};
        OFS_READ_PARAM: wb_dat_o <= {24'h0, read_param};
        OFS_BANK_ADDR: wb_dat_o <= {24'h0, bank_addr};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // command decode, evaluated against the range in force right now
  always_comb begin
    is_array_op = 1'b0;
    is_chip_erase = 1'b0;
    flags = '0;
    set_wel = 1'b0;
    clr_wel = 1'b0;
    do_status = 1'b0;
    do_array = 1'b0;
    do_param = 1'b0;
    do_bank = 1'b0;
    case (cmd_op)
      OP_WRITE_ENABLE: begin
        set_wel = 1'b1;
        flags[RS_ACCEPTED] = 1'b1;
      end
      OP_WRITE_DISABLE: begin
        clr_wel = 1'b1;
        flags[RS_ACCEPTED] = 1'b1;
      end
      OP_STATUS_WRITE: begin
        if (!write_enable_latch) begin
          flags[RS_NO_WEL] = 1'b1;
        end else if (sr_locked) begin
          flags[RS_LOCKED] = 1'b1;
        end else begin
          do_status = 1'b1;
          clr_wel = 1'b1;
          flags[RS_ACCEPTED] = 1'b1;
        end
      end
      OP_PAGE_PROG, OP_SECTOR_ERASE, OP_SECTOR_ERASE_ALT,
      OP_BLOCK_ERASE_32, OP_BLOCK_ERASE_64: begin
        is_array_op = 1'b1;
        if (!write_enable_latch) begin
          flags[RS_NO_WEL] = 1'b1;
        end else if (target_protected) begin
          flags[RS_PROTECTED] = 1'b1;
        end else begin
          do_array = 1'b1;
          clr_wel = 1'b1;
          flags[RS_ACCEPTED] = 1'b1;
        end
      end
      OP_CHIP_ERASE, OP_CHIP_ERASE_ALT: begin
        is_chip_erase = 1'b1;
        if (!write_enable_latch) begin
          flags[RS_NO_WEL] = 1'b1;
        end else if (protect_code != 4'h0) begin
          flags[RS_PROTECTED] = 1'b1;
        end else begin
          do_array = 1'b1;
          clr_wel = 1'b1;
          flags[RS_ACCEPTED] = 1'b1;
        end
      end
      OP_PARAM_FREE: begin
        do_param = 1'b1;
        flags[RS_ACCEPTED] = 1'b1;
      end
      OP_BANK_FREE: begin
        do_bank = 1'b1;
        flags[RS_ACCEPTED] = 1'b1;
      end
      OP_PARAM_LATCHED, OP_BANK_LATCHED: begin
        if (!write_enable_latch) begin
          flags[RS_NO_WEL] = 1'b1;
        end else begin
          do_param = (cmd_op == OP_PARAM_LATCHED);
          do_bank = (cmd_op == OP_BANK_LATCHED);
          clr_wel = 1'b1;
          flags[RS_ACCEPTED] = 1'b1;
        end
      end
      default: flags[RS_UNKNOWN] = 1'b1;
    endcase
  end

  // status: latch bit from commands, upper six bits only via status write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= STATUS_RESET;
    end else if (cmd_stb) begin
      if (do_status) begin
        status[7:2] <= cmd_data[7:2];
      end
      if (set_wel) begin
        status[ST_WEL] <= 1'b1;
      end else if (clr_wel) begin
        status[ST_WEL] <= 1'b0;
      end
    end
  end

  // one-way bit: writing 0 is ignored, so bottom can never revert
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_bottom_select <= 1'b0;
    end else if (wr_en & (wb_adr_i == OFS_FUNCTION) & wb_sel_i[0]) begin
      top_bottom_select <= top_bottom_select | wb_dat_i[FN_TBS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      large_blocks <= 1'b0;
      target <= '0;
    end else if (wr_en) begin
      if ((wb_adr_i == OFS_CONFIG) & wb_sel_i[0]) begin
        large_blocks <= wb_dat_i[CF_LARGE];
      end
      if (wb_adr_i == OFS_TARGET) begin
        for (int b = 0; b < 3; b++) begin
          if (wb_sel_i[b]) begin
            target[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
        if (wb_sel_i[3]) begin
          target[ADDR_W-1:24] <= wb_dat_i[ADDR_W-1:24];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_param <= PARAM_RESET;
      bank_addr <= BANK_RESET;
      result <= '0;
    end else if (cmd_stb) begin
      if (do_param) begin
        read_param <= cmd_data;
      end
      if (do_bank) begin
        bank_addr <= cmd_data;
      end
      result <= {cmd_op, 3'b000, flags};
    end
  end

  // the array sees only requests that passed the range check
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      array_op_o <= 1'b0;
      array_op_code_o <= '0;
      array_op_addr_o <= '0;
    end else begin
      array_op_o <= cmd_stb & do_array;
      if (cmd_stb & do_array) begin
        array_op_code_o <= cmd_op;
        array_op_addr_o <= target;
      end
    end
  end

  assign target_low = large_blocks ? (target[25:18] == 8'h00)
                                   : (target[25:16] == 10'h000);

  property p_refuse_protected;
    @(posedge clk_i) disable iff (rst_i)
    cmd_stb && is_array_op && target_protected |=> !array_op_o;
  endproperty
  a_refuse_protected: assert property (p_refuse_protected)
    else $error("program or erase reached a protected block");

  property p_chip_erase_code;
    @(posedge clk_i) disable iff (rst_i)
    cmd_stb && is_chip_erase |=> array_op_o == ($past(protect_code) == 4'h0
      && $past(write_enable_latch));
  endproperty
  a_chip_erase_code: assert property (p_chip_erase_code)
    else $error("chip erase outcome disagrees with protect code");

  property p_status_locked;
    @(posedge clk_i) disable iff (rst_i)
    cmd_stb && cmd_op == OP_STATUS_WRITE && sr_locked
      |=> $stable(status[7:2]);
  endproperty
  a_status_locked: assert property (p_status_locked)
    else $error("locked status register changed");

  property p_status_open;
    @(posedge clk_i) disable iff (rst_i)
    cmd_stb && cmd_op == OP_STATUS_WRITE && write_enable_latch
      && !sr_locked |=> status[7:2] == $past(cmd_data[7:2]) && !status[ST_WEL];
  endproperty
  a_status_open: assert property (p_status_open)
    else $error("status write was not applied");

  property p_quad_pins;
    @(posedge clk_i) disable iff (rst_i)
    quad_lines_en_o |-> !hold_active_o && !write_protect_active_o && !sr_locked;
  endproperty
  a_quad_pins: assert property (p_quad_pins)
    else $error("shared pin function active in quad mode");

  property p_count_pow;
    @(posedge clk_i) disable iff (rst_i)
    protect_code != 4'h0 && ((!large_blocks && protect_code <= CODE_POW_MAX_64K)
      || (large_blocks && protect_code <= CODE_POW_MAX_256K))
      |-> prot_count == (CNT_W'(1) << (protect_code - 4'd1));
  endproperty
  a_count_pow: assert property (p_count_pow)
    else $error("power-of-two block count wrong");

  property p_count_high;
    @(posedge clk_i) disable iff (rst_i)
    !large_blocks && protect_code >= CODE_768 |-> prot_count ==
      (protect_code == CODE_768 ? COUNT_768 : protect_code == CODE_896 ?
       COUNT_896 : protect_code == CODE_960 ? COUNT_960 :
       protect_code == CODE_992 ? COUNT_992 : BLOCKS_64K);
  endproperty
  a_count_high: assert property (p_count_high)
    else $error("upper protect code count wrong");

  property p_direction;
    @(posedge clk_i) disable iff (rst_i)
    prot_count != '0 && prot_count < (large_blocks ? BLOCKS_256K : BLOCKS_64K)
      && target_low |-> target_protected == top_bottom_select;
  endproperty
  a_direction: assert property (p_direction)
    else $error("protected range counted from the wrong end");

  property p_large_all;
    @(posedge clk_i) disable iff (rst_i)
    large_blocks && protect_code > CODE_POW_MAX_256K
      |-> prot_count == BLOCKS_256K && target_protected;
  endproperty
  a_large_all: assert property (p_large_all)
    else $error("large block code does not cover all blocks");

  property p_free_param;
    @(posedge clk_i) disable iff (rst_i)
    cmd_stb && cmd_op == OP_PARAM_FREE && !write_enable_latch
      |=> read_param == $past(cmd_data);
  endproperty
  a_free_param: assert property (p_free_param)
    else $error("parameter write without enable was refused");

  property p_one_way;
    @(posedge clk_i) disable iff (rst_i)
    top_bottom_select |=> top_bottom_select;
  endproperty
  a_one_way: assert property (p_one_way)
    else $error("top/bottom select returned to top");
endmodule // flash_block_write_protect

// File: flash_block_write_protect_tb_top.sv
`timescale 1ns/10ps
module flash_block_write_protect_tb_top;
  import flash_protect_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic hold_n = 1'b1;
  wire logic [7:0] adr;
  wire logic [31:0] wdat, rdat;
  wire logic [3:0] sel;
  wire logic we, stb, cyc, ack, quad, wp_act, hold_act, op_v;
  wire logic [7:0] op_code;
  wire logic [25:0] op_addr;
  int num_errors = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  flash_host_model host (.clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat),
    .wb_adr_o(adr), .wb_dat_o(wdat), .wb_sel_o(sel), .wb_we_o(we),
    .wb_stb_o(stb), .wb_cyc_o(cyc));

  flash_block_write_protect dut (.clk_i(clk), .rst_i(rst),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack),
    .wp_n_pin_i(wp_n), .hold_n_pin_i(hold_n), .quad_lines_en_o(quad),
    .write_protect_active_o(wp_act), .hold_active_o(hold_act),
    .array_op_o(op_v), .array_op_code_o(op_code),
    .array_op_addr_o(op_addr));

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    logic ok;
    host.access(w, a, d, r, ok);
    if (!ok) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] d);
    wr(OFS_COMMAND, {16'h0, d, op});
  endtask

  // latch first, as the host must for guarded commands
  task automatic wcmd(input logic [7:0] op, input logic [7:0] d);
    cmd(OP_WRITE_ENABLE, 8'h00);
    cmd(op, d);
  endtask

  function automatic int expcnt(int c, bit g);
    if (c == 0) return 0;
    if (g) return (c >= 9) ? 256 : (1 << (c - 1));
    case (c)
      11: return 768;
      12: return 896;
      13: return 960;
      14: return 992;
      15: return 1024;
      default: return 1 << (c - 1);
    endcase
  endfunction

  // program or erase one block and see whether it was refused
  task automatic probe(int b, int n, bit t, bit g, logic [7:0] o);
    logic [31:0] r;
    logic [31:0] a;
    bit p;
    p = t ? (b < n) : (b >= (g ? 256 : 1024) - n);
    a = g ? 32'(b) << 18 : 32'(b) << 16;
    wr(OFS_TARGET, a);
    wcmd(o, 8'h00);
    #1 chk_bit(op_v, !p);
    if (!p) chk_word({6'h0, op_addr}, a);
    if (!p) chk_word({24'h0, op_code}, {24'h0, o});
    bus(1'b0, OFS_RESULT, 32'h0, r);
    chk_word(r, {16'h0, o, 6'h0, p, !p});
  endtask

  initial begin
    int t, g, c, n, nb, i;
    logic [31:0] r;
    logic [7:0] op;
    logic [7:0] ops [4];
    logic [7:0] aops [5];
    aops = '{OP_PAGE_PROG, OP_SECTOR_ERASE, OP_SECTOR_ERASE_ALT,
      OP_BLOCK_ERASE_32, OP_BLOCK_ERASE_64};
    ops[0] = OP_PARAM_FREE;
    ops[1] = OP_BANK_FREE;
    ops[2] = OP_PARAM_LATCHED;
    ops[3] = OP_BANK_LATCHED;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0, r);
    chk_word(r, {24'h0, STATUS_RESET});
    bus(1'b0, OFS_READ_PARAM, 32'h0, r);
    chk_word(r, {24'h0, PARAM_RESET});
    bus(1'b0, OFS_FUNCTION, 32'h0, r);
    chk_bit(r[FN_TBS], 1'b0);
    wr(8'h40, 32'hffffffff);
    bus(1'b0, 8'h40, 32'h0, r);
    chk_word(r, 32'h0);
    for (t = 0; t < 2; t++) begin
      if (t == 1) begin
        wr(OFS_FUNCTION, 32'h2);
        wr(OFS_FUNCTION, 32'h0);
        bus(1'b0, OFS_FUNCTION, 32'h0, r);
        chk_bit(r[FN_TBS], 1'b1);
      end
      for (g = 0; g < 2; g++) begin
        wr(OFS_CONFIG, 32'(g));
        nb = g ? 256 : 1024;
        for (c = 0; c < 16; c++) begin
          wcmd(OP_STATUS_WRITE, 8'(c << 2));
          bus(1'b0, OFS_STATUS, 32'h0, r);
          chk_word(r, {24'h0, 2'b00, 4'(c), 2'b00});
          n = expcnt(c, g[0]);
          if (n > 0) probe(t ? n - 1 : nb - n, n, t[0], g[0], aops[c % 5]);
          if (n < nb) probe(t ? n : nb - n - 1, n, t[0], g[0], aops[c % 5]);
        end
      end
    end
    for (i = 0; i < 2; i++) begin
      op = i ? OP_CHIP_ERASE_ALT : OP_CHIP_ERASE;
      wcmd(OP_STATUS_WRITE, 8'h04);
      wcmd(op, 8'h00);
      #1 chk_bit(op_v, 1'b0);
      bus(1'b0, OFS_RESULT, 32'h0, r);
      chk_word(r, {16'h0, op, 8'h02});
      wcmd(OP_STATUS_WRITE, 8'h00);
      wcmd(op, 8'h00);
      #1 chk_bit(op_v, 1'b1);
      chk_word({24'h0, op_code}, {24'h0, op});
    end
    wcmd(OP_STATUS_WRITE, 8'h80);
    wcmd(OP_STATUS_WRITE, 8'h88);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    chk_word(r, 32'h88);
    wp_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_bit(wp_act, 1'b1);
    wcmd(OP_STATUS_WRITE, 8'h00);
    bus(1'b0, OFS_RESULT, 32'h0, r);
    chk_word(r, {16'h0, OP_STATUS_WRITE, 8'h08});
    bus(1'b0, OFS_STATUS, 32'h0, r);
    chk_word(r, 32'h8a);
    wp_n <= 1'b1;
    repeat (3) @(posedge clk);
    wcmd(OP_STATUS_WRITE, 8'h40);
    #1 chk_bit(quad, 1'b1);
    wp_n <= 1'b0;
    hold_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_bit(wp_act, 1'b0);
    chk_bit(hold_act, 1'b0);
    wcmd(OP_STATUS_WRITE, 8'h00);
    #1 chk_bit(quad, 1'b0);
    chk_bit(hold_act, 1'b1);
    chk_bit(wp_act, 1'b1);
    wp_n <= 1'b1;
    hold_n <= 1'b1;
    // status is command-only; a bus write must not land
    wr(OFS_STATUS, 32'hfc);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    chk_word(r, 32'h0);
    // latch is clear here, so only the free opcodes may land
    for (i = 0; i < 4; i++) begin
      cmd(ops[i], 8'h50 + 8'(i));
      bus(1'b0, OFS_RESULT, 32'h0, r);
      chk_word(r, {16'h0, ops[i], i < 2 ? 8'h01 : 8'h04});
      bus(1'b0, i % 2 ? OFS_BANK_ADDR : OFS_READ_PARAM, 32'h0, r);
      chk_word(r, 32'h50 + 32'(i % 2));
    end
    // the latched forms land once the latch is set
    wcmd(OP_PARAM_LATCHED, 8'h5a);
    bus(1'b0, OFS_READ_PARAM, 32'h0, r);
    chk_word(r, 32'h5a);
    wcmd(OP_BANK_LATCHED, 8'ha5);
    bus(1'b0, OFS_BANK_ADDR, 32'h0, r);
    chk_word(r, 32'ha5);
    // write disable drops the latch again
    cmd(OP_WRITE_ENABLE, 8'h00);
    cmd(OP_WRITE_DISABLE, 8'h00);
    cmd(OP_PAGE_PROG, 8'h00);
    #1 chk_bit(op_v, 1'b0);
    bus(1'b0, OFS_RESULT, 32'h0, r);
    chk_word(r, {16'h0, OP_PAGE_PROG, 8'h04});
    cmd(8'hee, 8'h00);
    bus(1'b0, OFS_RESULT, 32'h0, r);
    chk_word(r, {16'h0, 8'hee, 8'h10});
    wrap_up();
  end
endmodule // flash_block_write_protect_tb_top

// File: flash_host_model.sv
`timescale 1ns/10ps
module flash_host_model (
  input wire logic clk_i, // system clock
  input wire logic wb_ack_i, // slave acknowledge
  input wire logic [31:0] wb_dat_i, // read data from slave
  output logic [7:0] wb_adr_o, // byte address
  output logic [31:0] wb_dat_o, // write data
  output logic [3:0] wb_sel_o, // byte selects
  output logic wb_we_o, // write
  output logic wb_stb_o, // strobe
  output logic wb_cyc_o // cycle
);
  initial begin
    wb_adr_o = 8'h00;
    wb_dat_o = 32'h0;
    wb_sel_o = 4'h0;
    wb_we_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_cyc_o = 1'b0;
  end

  // request held until ack sampled high or 16 edges pass; each access first waits one clock edge, leaving one idle cycle
  task automatic access(input logic we, input logic [7:0] adr,
      input logic [31:0] wdat, output logic [31:0] rdat,
      output logic ok);
    int n;
    ok = 1'b0;
    rdat = 32'h0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_dat_o <= wdat;
    wb_sel_o <= 4'hf;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        rdat = wb_dat_i;
      end
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
  endtask
endmodule // flash_host_model

// File: flash_protect_pkg.sv
package flash_protect_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_FUNCTION = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_TARGET = 8'h0c;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_READ_PARAM = 8'h18;
  localparam logic [7:0] OFS_BANK_ADDR = 8'h1c;

  // status register fields
  localparam int ST_WEL = 1;
  localparam int ST_CODE_LSB = 2;
  localparam int ST_QE = 6;
  localparam int ST_SWD = 7;
  localparam logic [7:0] ST_WRITABLE = 8'hfc;
  // function and config fields
  localparam int FN_TBS = 1;
  localparam int CF_LARGE = 0;
  // result register flags
  localparam int RS_ACCEPTED = 0;
  localparam int RS_PROTECTED = 1;
  localparam int RS_NO_WEL = 2;
  localparam int RS_LOCKED = 3;
  localparam int RS_UNKNOWN = 4;
  localparam int RS_OP_LSB = 8;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;

  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE_ALT = 8'hd7;
  localparam logic [7:0] OP_BLOCK_ERASE_32 = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE_64 = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] OP_PARAM_FREE = 8'hc0;
  localparam logic [7:0] OP_PARAM_LATCHED = 8'h63;
  localparam logic [7:0] OP_BANK_FREE = 8'h17;
  localparam logic [7:0] OP_BANK_LATCHED = 8'hc5;

  // array geometry
  localparam int ADDR_W = 26;
  localparam int CNT_W = 11;
  localparam logic [3:0] CODE_ALL = 4'hf;
  localparam logic [3:0] CODE_POW_MAX_64K = 4'ha;
  localparam logic [3:0] CODE_POW_MAX_256K = 4'h8;
  localparam logic [3:0] CODE_768 = 4'hb;
  localparam logic [3:0] CODE_896 = 4'hc;
  localparam logic [3:0] CODE_960 = 4'hd;
  localparam logic [3:0] CODE_992 = 4'he;
  localparam logic [CNT_W-1:0] BLOCKS_64K = 11'd1024;
  localparam logic [CNT_W-1:0] BLOCKS_256K = 11'd256;
  localparam logic [CNT_W-1:0] COUNT_768 = 11'd768;
  localparam logic [CNT_W-1:0] COUNT_896 = 11'd896;
  localparam logic [CNT_W-1:0] COUNT_960 = 11'd960;
  localparam logic [CNT_W-1:0] COUNT_992 = 11'd992;
endpackage

// File: pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic [W-1:0] pin_i, // asynchronous pins
  output logic [W-1:0] sync_o // synchronised levels
);
  logic [W-1:0] stage1;

  // pins idle high, so reset to ones avoids a false assertion
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stage1[i] <= 1'b1;
          sync_o[i] <= 1'b1;
        end else begin
          stage1[i] <= pin_i[i];
          sync_o[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync

// File: protect_range_decoder.sv
`timescale 1ns/10ps
module protect_range_decoder
  import flash_protect_pkg::*;
(
  input wire logic [3:0] code_i, // block protect code
  input wire logic tbs_i, // 1 counts from block zero
  input wire logic large_i, // 256KB block geometry
  input wire logic [flash_protect_pkg::ADDR_W-1:0] addr_i, // target
  output logic [flash_protect_pkg::CNT_W-1:0] count_o, // protected blocks
  output logic protected_o // target inside range
);
  logic [CNT_W-1:0] idx;
  logic [CNT_W-1:0] total;
  logic [CNT_W-1:0] pow;

  assign pow = CNT_W'(1) << (code_i - 4'd1);

  always_comb begin
    count_o = '0;
    if (large_i) begin
      if (code_i > CODE_POW_MAX_256K) begin
        count_o = BLOCKS_256K;
      end else if (code_i != 4'h0) begin
        count_o = pow;
      end
    end else begin
      unique case (code_i)
        CODE_768: count_o = COUNT_768;
        CODE_896: count_o = COUNT_896;
        CODE_960: count_o = COUNT_960;
        CODE_992: count_o = COUNT_992;
        CODE_ALL: count_o = BLOCKS_64K;
        4'h0: count_o = '0;
        default: count_o = pow;
      endcase
    end
  end

  assign idx = large_i ? {3'b000, addr_i[25:18]} : {1'b0, addr_i[25:16]};
  assign total = large_i ? BLOCKS_256K : BLOCKS_64K;

  // top counts down from the last block, bottom up from block zero
  always_comb begin
    if (count_o == '0) begin
      protected_o = 1'b0;
    end else if (tbs_i) begin
      protected_o = idx < count_o;
    end else begin
      protected_o = idx >= (total - count_o);
    end
  end
endmodule // protect_range_decoder
